// File: cide_pkg.sv
// Shared encodings, field positions and states of the instruction decode and execute block
package cide_pkg;
  localparam int OPC_MSB = 31;
  localparam int OPC_LSB = 26;
  localparam int FLAG_A_BIT = 25;
  localparam int FLAG_B_BIT = 24;
  localparam int DST_MSB = 23;
  localparam int DST_LSB = 16;
  localparam int SRCA_MSB = 15;
  localparam int SRCA_LSB = 8;
  localparam int SRCB_MSB = 7;
  localparam int SRCB_LSB = 0;
  localparam int SHORT_HI_MSB = 28;
  localparam int SHORT_HI_LSB = 24;
  localparam int SHORT_LO_MSB = 15;

  localparam logic [5:0] OP_NOP = 6'h00;
  localparam logic [5:0] OP_LOAD_CONST = 6'h01;
  localparam logic [5:0] OP_HLT = 6'h02;
  localparam logic [5:0] OP_LOAD_WORD = 6'h08;
  localparam logic [5:0] OP_LUB = 6'h0A;
  localparam logic [5:0] OP_LSB = 6'h0B;
  localparam logic [5:0] OP_STORE_WORD = 6'h0C;
  localparam logic [5:0] OP_STORE_BYTE = 6'h0E;
  localparam logic [5:0] OP_ADD = 6'h10;
  localparam logic [5:0] OP_SUB = 6'h11;
  localparam logic [5:0] OP_MUL = 6'h12;
  localparam logic [5:0] OP_DIVU = 6'h14;
  localparam logic [5:0] OP_DIVS = 6'h15;
  localparam logic [5:0] OP_MODU = 6'h16;
  localparam logic [5:0] OP_MODS = 6'h17;
  localparam logic [5:0] OP_AND = 6'h18;
  localparam logic [5:0] OP_OR = 6'h19;
  localparam logic [5:0] OP_XOR = 6'h1A;
  localparam logic [5:0] OP_SHIFT_LEFT = 6'h1C;
  localparam logic [5:0] OP_SRU = 6'h1E;
  localparam logic [5:0] OP_SRS = 6'h1F;
  localparam logic [5:0] OP_JMP = 6'h20;
  localparam logic [5:0] OP_CALL = 6'h21;
  localparam logic [5:0] OP_CJ_EQ = 6'h38;
  localparam logic [1:0] CJMP_PREFIX = 2'h3;
  localparam logic [2:0] SHORT_PREFIX = 3'h5;

  localparam logic [7:0] RETURN_POINTER_INDEX = 8'hFE;
  localparam logic [7:0] IRQ_RETURN_INDEX = 8'hFF;
  localparam logic [31:0] INSTR_STEP = 32'h0000_0004;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [3:0] SEL_WORD = 4'hF;
  localparam logic [3:0] SEL_BYTE0 = 4'h1;
  localparam int DIV_STEPS = 32;

  typedef enum logic [2:0] {ST_IDLE, ST_CONST, ST_DIV, ST_MEM, ST_HALT} cide_state_type;
endpackage : cide_pkg

// File: cide_alu.sv
// Single-cycle arithmetic, logic, shift and multiply datapath
`timescale 1ns/1ps
module cide_alu
  import cide_pkg::*;
(
  input wire logic [5:0] opcode_i,
  input wire logic [31:0] a_i,
  input wire logic [31:0] b_i,
  output logic [31:0] result_o
);
  logic [63:0] product;

  // Low half of the product is the same for signed and unsigned operands
  assign product = a_i * b_i;

  always_comb
  begin
    case (opcode_i)
      OP_ADD: result_o = a_i + b_i;
      OP_SUB: result_o = a_i - b_i;
      OP_MUL: result_o = product[31:0];
      OP_AND: result_o = a_i & b_i;
      OP_OR: result_o = a_i | b_i;
      OP_XOR: result_o = a_i ^ b_i;
      // Only five amount bits are used; larger amounts shift by their value modulo 32
      OP_SHIFT_LEFT: result_o = a_i << b_i[4:0];
      OP_SRU: result_o = a_i >> b_i[4:0];
      OP_SRS: result_o = 32'($signed(a_i) >>> b_i[4:0]);
      default: result_o = RESET_WORD;
    endcase
  end
endmodule : cide_alu

// File: cide_divider.sv
// Iterative restoring divider giving quotient or remainder, signed or unsigned
`timescale 1ns/1ps
module cide_divider
  import cide_pkg::*;
#(
  parameter int WIDTH = DIV_STEPS
)
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic start_i,
  input wire logic signed_i,
  input wire logic rem_i,
  input wire logic [WIDTH-1:0] dividend_i,
  input wire logic [WIDTH-1:0] divisor_i,
  output logic done_o,
  output logic [WIDTH-1:0] result_o
);
  localparam int CW = $clog2(WIDTH + 1);
  logic [WIDTH:0] rem;
  logic [WIDTH-1:0] quo;
  logic [WIDTH-1:0] dvs;
  logic [CW-1:0] count;
  logic neg_q;
  logic neg_r;
  logic want_rem;
  logic neg_dd;
  logic neg_dv;
  logic [WIDTH:0] shifted;
  logic [WIDTH:0] diff;
  logic [WIDTH:0] next_rem;
  logic [WIDTH-1:0] next_quo;

  assign neg_dd = signed_i & dividend_i[WIDTH-1];
  assign neg_dv = signed_i & divisor_i[WIDTH-1];
  assign shifted = {rem[WIDTH-1:0], quo[WIDTH-1]};
  assign diff = shifted - {1'b0, dvs};
  assign next_rem = diff[WIDTH] ? shifted : diff;
  assign next_quo = {quo[WIDTH-2:0], ~diff[WIDTH]};

  // Works on magnitudes so both quotients round towards zero
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      rem <= '0;
      quo <= '0;
      dvs <= '0;
      count <= '0;
      neg_q <= 1'b0;
      neg_r <= 1'b0;
      want_rem <= 1'b0;
      done_o <= 1'b0;
      result_o <= '0;
    end
    else if (start_i)
    begin
      rem <= '0;
      quo <= neg_dd ? -dividend_i : dividend_i;
      dvs <= neg_dv ? -divisor_i : divisor_i;
      count <= CW'(WIDTH);
      neg_q <= neg_dd ^ neg_dv;
      neg_r <= neg_dd;
      want_rem <= rem_i;
      done_o <= 1'b0;
    end
    else if (count != '0)
    begin
      rem <= next_rem;
      quo <= next_quo;
      count <= count - CW'(1);
      done_o <= (count == CW'(1));
      if (count == CW'(1))
      begin
        if (want_rem)
          result_o <= neg_r ? -next_rem[WIDTH-1:0] : next_rem[WIDTH-1:0];
        else
          result_o <= neg_q ? -next_quo : next_quo;
      end
    end
    else
    begin
      done_o <= 1'b0;
    end
  end
endmodule : cide_divider

// File: cide_core.sv
// Instruction decode and execute unit with register file, data bus and halt control
`timescale 1ns/1ps
module cide_core
  import cide_pkg::*;
#(
  parameter bit HAS_DIVIDER = 1'b1
)
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [31:0] instr_i,
  input wire logic [31:0] instr_addr_i,
  input wire logic instr_valid_i,
  output logic instr_ready_o,
  output logic jump_valid_o,
  output logic [31:0] jump_addr_o,
  output logic dbus_cyc_o,
  output logic dbus_we_o,
  output logic [31:0] dbus_adr_o,
  output logic [31:0] dbus_dat_o,
  output logic [3:0] dbus_sel_o,
  input wire logic [31:0] dbus_dat_i,
  input wire logic dbus_ack_i,
  input wire logic irq_i,
  output logic halted_o,
  output logic wb_valid_o,
  output logic [7:0] wb_reg_o,
  output logic [31:0] wb_data_o
);
  import cide_pkg::*;

  cide_state_type state;
  cide_state_type next_state;
  logic [31:0] regs [256];
  logic [5:0] opcode;
  logic src_a_is_reg_flag;
  logic src_b_is_reg_flag;
  logic [7:0] dst_field;
  logic [7:0] src_a_field;
  logic [7:0] src_b_field;
  logic [31:0] a_val;
  logic [31:0] b_val;
  logic [31:0] dst_val;
  logic [31:0] short_constant_value;
  logic [31:0] alu_result;
  logic [31:0] div_result;
  logic div_done;
  logic accept;
  logic cond_true;
  logic is_div_op;
  logic load_full_constant_op;
  logic load_word_op;
  logic store_word_op;
  logic store_byte_op;
  logic shift_left_op;
  logic [5:0] hold_opc;
  logic [7:0] hold_dst;
  logic [1:0] hold_off;
  logic [7:0] load_byte;
  logic [31:0] load_val;
  logic next_wr_en;
  logic [7:0] next_wr_addr;
  logic [31:0] next_wr_data;
  logic next_jump;
  logic [31:0] next_jump_addr;
  logic next_bus;
  logic div_start;

  // Field split of the instruction word
  assign opcode = instr_i[OPC_MSB:OPC_LSB];
  assign src_a_is_reg_flag = instr_i[FLAG_A_BIT];
  assign src_b_is_reg_flag = instr_i[FLAG_B_BIT];
  assign dst_field = instr_i[DST_MSB:DST_LSB];
  assign src_a_field = instr_i[SRCA_MSB:SRCA_LSB];
  assign src_b_field = instr_i[SRCB_MSB:SRCB_LSB];

  // Register or sign-extended immediate per operand
  assign a_val = src_a_is_reg_flag ? regs[src_a_field] : {{24{src_a_field[7]}}, src_a_field};
  assign b_val = src_b_is_reg_flag ? regs[src_b_field] : {{24{src_b_field[7]}}, src_b_field};
  assign dst_val = regs[dst_field];
  assign short_constant_value = {{11{instr_i[SHORT_HI_MSB]}}, instr_i[SHORT_HI_MSB:SHORT_HI_LSB],
    instr_i[SHORT_LO_MSB:0]};

  assign accept = instr_valid_i & instr_ready_o;
  assign is_div_op = (opcode == OP_DIVU) || (opcode == OP_DIVS) || (opcode == OP_MODU)
    || (opcode == OP_MODS);
  assign load_full_constant_op = (opcode == OP_LOAD_CONST);
  assign load_word_op = (opcode == OP_LOAD_WORD) || (opcode == OP_LUB) || (opcode == OP_LSB);
  assign store_word_op = (opcode == OP_STORE_WORD);
  assign store_byte_op = (opcode == OP_STORE_BYTE);
  assign shift_left_op = (opcode == OP_SHIFT_LEFT);

  // Low condition bits: 3 equal, 2 not equal, 1 unsigned greater, 0 signed greater
  assign cond_true = (opcode[3] && (a_val == b_val))
    || (opcode[2] && (a_val != b_val))
    || (opcode[1] && (a_val > b_val))
    || (opcode[0] && ($signed(a_val) > $signed(b_val)));

  cide_alu u_alu
  (
    .opcode_i(opcode),
    .a_i(a_val),
    .b_i(b_val),
    .result_o(alu_result)
  );

  cide_divider #(.WIDTH(DIV_STEPS)) u_div
  (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .start_i(div_start),
    .signed_i(opcode[0]),
    .rem_i(opcode[1]),
    .dividend_i(a_val),
    .divisor_i(b_val),
    .done_o(div_done),
    .result_o(div_result)
  );

  // Byte lane picked by the low address bits, little-endian
  always_comb
  begin
    unique case (hold_off)
      2'h0: load_byte = dbus_dat_i[7:0];
      2'h1: load_byte = dbus_dat_i[15:8];
      2'h2: load_byte = dbus_dat_i[23:16];
      2'h3: load_byte = dbus_dat_i[31:24];
    endcase
    if (hold_opc == OP_LUB)
      load_val = {24'h00_0000, load_byte};
    else if (hold_opc == OP_LSB)
      load_val = {{24{load_byte[7]}}, load_byte};
    else
      load_val = dbus_dat_i;
  end

  always_comb
  begin
    next_state = state;
    next_wr_en = 1'b0;
    next_wr_addr = dst_field;
    next_wr_data = alu_result;
    next_jump = 1'b0;
    next_jump_addr = a_val;
    next_bus = 1'b0;
    div_start = 1'b0;
    unique case (state)
      ST_IDLE:
      begin
        if (accept)
        begin
          if (instr_i[31:29] == SHORT_PREFIX)
          begin
            next_wr_en = 1'b1;
            next_wr_data = short_constant_value;
          end
          else if (opcode[5:4] == CJMP_PREFIX)
          begin
            // The destination field names the target and is never written
            next_jump = cond_true;
            next_jump_addr = dst_val;
          end
          else
          begin
            case (opcode)
              OP_LOAD_CONST: next_state = ST_CONST;
              OP_HLT: next_state = ST_HALT;
              OP_LOAD_WORD, OP_LUB, OP_LSB, OP_STORE_WORD, OP_STORE_BYTE:
              begin
                next_bus = 1'b1;
                next_state = ST_MEM;
              end
              OP_ADD, OP_SUB, OP_MUL, OP_AND, OP_OR, OP_XOR, OP_SHIFT_LEFT, OP_SRU, OP_SRS:
              begin
                next_wr_en = 1'b1;
              end
              OP_DIVU, OP_DIVS, OP_MODU, OP_MODS:
              begin
                if (HAS_DIVIDER)
                begin
                  div_start = 1'b1;
                  next_state = ST_DIV;
                end
                else
                begin
                  next_wr_en = 1'b1;
                  next_wr_data = RESET_WORD;
                end
              end
              OP_JMP:
              begin
                // Returns reach here with the return pointer as the source
                next_jump = 1'b1;
              end
              OP_CALL:
              begin
                next_jump = 1'b1;
                next_wr_en = 1'b1;
                next_wr_addr = RETURN_POINTER_INDEX;
                next_wr_data = instr_addr_i + INSTR_STEP;
              end
              // Nop and unassigned codes write nothing and stay idle; only the hold registers load
              default: next_state = ST_IDLE;
            endcase
          end
        end
      end
      ST_CONST:
      begin
        if (accept)
        begin
          next_wr_en = 1'b1;
          next_wr_addr = hold_dst;
          next_wr_data = instr_i;
          next_state = ST_IDLE;
        end
      end
      ST_DIV:
      begin
        if (div_done)
        begin
          next_wr_en = 1'b1;
          next_wr_addr = hold_dst;
          next_wr_data = div_result;
          next_state = ST_IDLE;
        end
      end
      ST_MEM:
      begin
        if (dbus_ack_i)
        begin
          next_wr_en = !hold_opc[2];
          next_wr_addr = hold_dst;
          next_wr_data = load_val;
          next_state = ST_IDLE;
        end
      end
      ST_HALT:
      begin
        if (irq_i)
          next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // Fetch gets a dead cycle after any jump so stale words are not taken
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      instr_ready_o <= 1'b0;
      halted_o <= 1'b0;
    end
    else
    begin
      instr_ready_o <= ((next_state == ST_IDLE) || (next_state == ST_CONST)) && !next_jump;
      halted_o <= (next_state == ST_HALT);
    end
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      hold_opc <= OP_NOP;
      hold_dst <= 8'h00;
      hold_off <= 2'h0;
    end
    else if (accept && (state == ST_IDLE))
    begin
      hold_opc <= opcode;
      hold_dst <= dst_field;
      hold_off <= a_val[1:0];
    end
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      jump_valid_o <= 1'b0;
      jump_addr_o <= RESET_WORD;
    end
    else
    begin
      jump_valid_o <= next_jump;
      if (next_jump)
        jump_addr_o <= next_jump_addr;
    end
  end

  // Bus cycle held until acknowledged; the address operand is a register or a sign-extended immediate per its flag
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      dbus_cyc_o <= 1'b0;
      dbus_we_o <= 1'b0;
      dbus_adr_o <= RESET_WORD;
      dbus_dat_o <= RESET_WORD;
      dbus_sel_o <= 4'h0;
    end
    else if (next_bus)
    begin
      dbus_cyc_o <= 1'b1;
      dbus_we_o <= store_word_op || store_byte_op;
      dbus_adr_o <= a_val;
      dbus_dat_o <= store_byte_op ? {4{b_val[7:0]}} : b_val;
      dbus_sel_o <= (store_byte_op || (load_word_op && !(opcode == OP_LOAD_WORD)))
        ? SEL_BYTE0 << a_val[1:0] : SEL_WORD;
    end
    else if (dbus_ack_i)
    begin
      dbus_cyc_o <= 1'b0;
      dbus_we_o <= 1'b0;
    end
  end

  // Register file has no reset; software must load before use
  always_ff @(posedge clk_i)
  begin
    if (next_wr_en)
      regs[next_wr_addr] <= next_wr_data;
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      wb_valid_o <= 1'b0;
      wb_reg_o <= 8'h00;
      wb_data_o <= RESET_WORD;
    end
    else
    begin
      wb_valid_o <= next_wr_en;
      if (next_wr_en)
      begin
        wb_reg_o <= next_wr_addr;
        wb_data_o <= next_wr_data;
      end
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  a_add_result: assert property (accept && state == ST_IDLE && instr_i[31:29] != SHORT_PREFIX
    && opcode == OP_ADD |=> wb_valid_o && wb_data_o == $past(a_val) + $past(b_val))
    else $error("add result wrong");
  a_sub_result: assert property (accept && state == ST_IDLE && opcode == OP_SUB
    |=> wb_valid_o && wb_data_o == $past(a_val) - $past(b_val))
    else $error("sub result wrong");
  a_shift_left: assert property (accept && state == ST_IDLE && shift_left_op && b_val < 32
    |=> wb_data_o == ($past(a_val) << $past(b_val[4:0])))
    else $error("shift left wrong");
  a_call_link: assert property (accept && state == ST_IDLE && opcode == OP_CALL
    |=> wb_reg_o == RETURN_POINTER_INDEX && wb_data_o == $past(instr_addr_i) + INSTR_STEP
    && jump_valid_o && jump_addr_o == $past(a_val))
    else $error("call link wrong");
  a_jump_no_write: assert property (accept && state == ST_IDLE && (opcode == OP_JMP
    || opcode[5:4] == CJMP_PREFIX) |=> !wb_valid_o ##1 (!wb_valid_o || $past(accept)))
    else $error("jump wrote a register");
  a_cjmp_equal: assert property (accept && state == ST_IDLE && opcode == OP_CJ_EQ
    |=> jump_valid_o == ($past(a_val) == $past(b_val))
    && (!jump_valid_o || jump_addr_o == $past(dst_val)))
    else $error("compare jump wrong");
  a_halt_hold: assert property (accept && state == ST_IDLE && opcode == OP_HLT && !irq_i
    |=> halted_o && !instr_ready_o)
    else $error("halt not taken");
  a_nop_quiet: assert property (accept && state == ST_IDLE && instr_i == RESET_WORD
    |=> !wb_valid_o && !jump_valid_o && !dbus_cyc_o && instr_ready_o)
    else $error("nop changed state");
  a_full_const: assert property (accept && state == ST_CONST
    |=> wb_valid_o && wb_reg_o == $past(hold_dst) && wb_data_o == $past(instr_i))
    else $error("full constant wrong");
  a_short_const: assert property (accept && state == ST_IDLE
    && instr_i[31:29] == SHORT_PREFIX |=> wb_data_o == $past(short_constant_value))
    else $error("short constant wrong");
  a_store_byte: assert property (accept && state == ST_IDLE && store_byte_op
    |=> dbus_cyc_o && dbus_we_o && dbus_sel_o == (SEL_BYTE0 << dbus_adr_o[1:0]))
    else $error("store byte lanes wrong");
  a_no_divider: assert property (!HAS_DIVIDER && accept && state == ST_IDLE && is_div_op
    |=> wb_valid_o && wb_data_o == RESET_WORD)
    else $error("divide without divider not zero");
  a_div_latency: assert property (div_start |-> ##[30:40] wb_valid_o)
    else $error("divide never finished");

  c_call: cover property (accept && state == ST_IDLE && opcode == OP_CALL);
  c_load_byte: cover property (state == ST_MEM && dbus_ack_i && hold_opc == OP_LSB);
  c_halt_wake: cover property (state == ST_HALT && irq_i);
  c_divide: cover property (div_done);
endmodule : cide_core

// File: cide_dbus_model.sv
// Data bus memory model that answers loads and stores after a set delay
`timescale 1ns/1ps
module cide_dbus_model
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic cyc_i,
  input wire logic we_i,
  input wire logic [31:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  input wire logic [3:0] lat_i,
  output logic [31:0] dat_o,
  output logic ack_o
);
  logic [31:0] mem [16];
  logic [3:0] cnt;
  // Outside the ack cycle the lines show inverted data, so a late read is caught
  assign dat_o = ack_o ? mem[adr_i[5:2]] : ~mem[adr_i[5:2]];
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      cnt <= 4'h0;
      ack_o <= 1'b0;
    end
    else
    begin
      ack_o <= cyc_i && !ack_o && cnt == lat_i;
      cnt <= (cyc_i && !ack_o) ? cnt + 4'h1 : 4'h0;
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (cyc_i && we_i && ack_o)
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (sel_i[i])
        begin
          mem[adr_i[5:2]][8*i +: 8] <= dat_i[8*i +: 8];
        end
      end
    end
  end
endmodule : cide_dbus_model

// File: test_cpu_instruction_decode_execute.sv
// Testbench for the instruction decode and execute core
`timescale 1ns/1ps
module test_cpu_instruction_decode_execute;
  import cide_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic instr_valid_i = 1'b0;
  logic irq_i = 1'b0;
  logic [31:0] instr_i = 32'h0;
  logic [31:0] instr_addr_i = 32'h0;
  logic instr_ready_o, jump_valid_o, dbus_cyc_o, dbus_we_o, dbus_ack_i, halted_o, wb_valid_o;
  logic [31:0] jump_addr_o, dbus_adr_o, dbus_dat_o, dbus_dat_i, wb_data_o;
  logic [3:0] dbus_sel_o;
  logic [3:0] lat = 4'h0;
  logic [7:0] wb_reg_o;
  int miscompares = 0;
  int samples_checked = 0;
  always #5 clk_i = ~clk_i;
  cide_core cide_core_inst (.*);
  cide_dbus_model cide_dbus_model_inst (.clk_i(clk_i), .reset_i(reset_i), .cyc_i(dbus_cyc_o),
    .we_i(dbus_we_o), .adr_i(dbus_adr_o), .dat_i(dbus_dat_o), .sel_i(dbus_sel_o),
    .lat_i(lat), .dat_o(dbus_dat_i), .ack_o(dbus_ack_i));

  function automatic logic [31:0] w(logic [5:0] o, logic ta, logic tb, logic [7:0] d,
    logic [7:0] a, logic [7:0] b);
    return {o, ta, tb, d, a, b};
  endfunction : w

  function automatic logic [31:0] f(logic [5:0] o, logic [31:0] a, logic [31:0] b);
    case (o)
      OP_ADD: return a + b;
      OP_SUB: return a - b;
      OP_MUL: return a * b;
      OP_DIVU: return a / b;
      OP_DIVS: return $signed(a) / $signed(b);
      OP_MODU: return a % b;
      OP_MODS: return $signed(a) % $signed(b);
      OP_AND: return a & b;
      OP_OR: return a | b;
      OP_XOR: return a ^ b;
      OP_SHIFT_LEFT: return a << b[4:0];
      OP_SRU: return a >> b[4:0];
      default: return $signed(a) >>> b[4:0];
    endcase
  endfunction : f

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done

  task automatic chk(string n, logic [79:0] s, logic [79:0] e);
    samples_checked++;
    if (s !== e)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic lim(int n);
    if (n >= 100)
    begin
      miscompares++;
      test_done();
    end
  endtask : lim

  // Leaves valid high so the second word of a full constant follows back to back
  task automatic put(logic [31:0] x);
    int n;
    n = 0;
    if (instr_valid_i === 1'b0)
      @(negedge clk_i);
    while (instr_ready_o !== 1'b1 && n < 100)
    begin
      @(negedge clk_i);
      n++;
    end
    lim(n);
    instr_i = x;
    instr_valid_i = 1'b1;
    @(negedge clk_i);
  endtask : put

  task automatic ex(logic [31:0] x);
    int n;
    n = 0;
    put(x);
    instr_valid_i = 1'b0;
    while ((wb_valid_o | jump_valid_o | halted_o | instr_ready_o) !== 1'b1 && n < 100)
    begin
      @(negedge clk_i);
      n++;
    end
    lim(n);
  endtask : ex

  task automatic t_regs;
    logic [7:0] d [7] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h09};
    logic [20:0] v [7] = '{21'h1FFF9C, 21'h0FFFFF, 21'h000010, 21'h1FFFFF, 21'h000001,
      21'h000100, 21'h000013};
    put(w(OP_LOAD_CONST, 1'b0, 1'b0, 8'h01, 8'h00, 8'h00));
    ex(32'h12345678);
    chk("const", {wb_reg_o, wb_data_o}, {8'h01, 32'h12345678});
    for (int i = 0; i < 7; i++)
    begin
      ex({3'h5, v[i][20:16], d[i], v[i][15:0]});
      chk("short", {wb_reg_o, wb_data_o}, {d[i], {11{v[i][20]}}, v[i]});
    end
    ex(32'h0);
    chk("idle", {wb_valid_o, jump_valid_o, halted_o}, 3'h0);
  endtask : t_regs

  task automatic t_alu;
    logic [5:0] op [13] = '{OP_ADD, OP_SUB, OP_MUL, OP_AND, OP_OR, OP_XOR, OP_SHIFT_LEFT,
      OP_SRU, OP_SRS, OP_DIVU, OP_DIVS, OP_MODU, OP_MODS};
    logic [7:0] fa [3] = '{8'h01, 8'h02, 8'hFD};
    logic [7:0] fb [3] = '{8'h1B, 8'h04, 8'h07};
    logic [31:0] va [3] = '{32'h12345678, 32'hFFFFFF9C, 32'hFFFFFFFD};
    logic [31:0] vb [3] = '{32'h1B, 32'h10, 32'h7};
    for (int r = 0; r < 3; r++)
      for (int k = 0; k < 13; k++)
      begin
        ex(w(op[k], r != 2, r == 1, 8'h20, fa[r], fb[r]));
        chk("alu", {wb_reg_o, wb_data_o}, {8'h20, f(op[k], va[r], vb[r])});
      end
  endtask : t_alu

  task automatic t_mem;
    ex(w(OP_STORE_WORD, 1'b1, 1'b1, 8'h00, 8'h04, 8'h01));
    chk("store", wb_valid_o, 1'b0);
    lat = 4'h3;
    ex(w(OP_STORE_BYTE, 1'b1, 1'b0, 8'h00, 8'h09, 8'h85));
    ex(w(OP_LOAD_WORD, 1'b1, 1'b0, 8'h0A, 8'h04, 8'h00));
    chk("word", wb_data_o, 32'h85345678);
    ex(w(OP_LUB, 1'b1, 1'b0, 8'h0A, 8'h09, 8'h00));
    chk("ubyte", wb_data_o, 32'h85);
    ex(w(OP_LSB, 1'b1, 1'b0, 8'h0A, 8'h09, 8'h00));
    chk("sbyte", wb_data_o, 32'hFFFFFF85);
  endtask : t_mem

  task automatic t_jump;
    logic [5:0] cc [6] = '{6'h38, 6'h34, 6'h31, 6'h39, 6'h32, 6'h3A};
    logic [31:0] a;
    logic [31:0] b;
    logic t;
    ex(w(OP_JMP, 1'b1, 1'b0, 8'h00, 8'h07, 8'h00));
    chk("jump", {jump_valid_o, wb_valid_o, jump_addr_o}, {2'h2, 32'h100});
    instr_addr_i = 32'h40;
    ex(w(OP_CALL, 1'b1, 1'b0, RETURN_POINTER_INDEX, 8'h07, 8'h00));
    chk("call", {jump_valid_o, jump_addr_o, wb_reg_o, wb_data_o},
      {1'b1, 32'h100, RETURN_POINTER_INDEX, 32'h44});
    ex(w(OP_JMP, 1'b1, 1'b0, 8'h00, RETURN_POINTER_INDEX, 8'h00));
    chk("return", {jump_valid_o, jump_addr_o}, {1'b1, 32'h44});
    // Pair 1 swaps the sources, as software does for the less-than forms
    for (int i = 0; i < 6; i++)
      for (int j = 0; j < 3; j++)
      begin
        a = j == 1 ? 32'h1 : 32'hFFFFFFFF;
        b = j == 0 ? 32'h1 : 32'hFFFFFFFF;
        // Order of cc: equal, not equal, signed gt, signed ge, unsigned gt, unsigned ge
        t = i == 0 ? a == b : i == 1 ? a != b : i == 2 ? $signed(a) > $signed(b)
          : i == 3 ? $signed(a) >= $signed(b) : i == 4 ? a > b : a >= b;
        ex(w(cc[i], 1'b1, 1'b1, 8'h07, j == 1 ? 8'h06 : 8'h05, j == 0 ? 8'h06 : 8'h05));
        chk("cond", {jump_valid_o, wb_valid_o, t ? jump_addr_o : 32'h0},
          {t, 1'b0, t ? 32'h100 : 32'h0});
      end
  endtask : t_jump

  task automatic t_halt;
    ex(w(OP_HLT, 1'b0, 1'b0, 8'h00, 8'h00, 8'h00));
    repeat (3) @(negedge clk_i);
    chk("halt", {halted_o, instr_ready_o}, 2'h2);
    irq_i = 1'b1;
    @(negedge clk_i);
    irq_i = 1'b0;
    chk("wake", {halted_o, instr_ready_o}, 2'h1);
  endtask : t_halt

  initial
  begin
    repeat (16) @(negedge clk_i);
    reset_i = 1'b0;
    @(negedge clk_i);
    t_regs();
    t_alu();
    t_mem();
    t_jump();
    t_halt();
    test_done();
  end
endmodule : test_cpu_instruction_decode_execute
